/* umc_mode_clk_cfg.sv */
// Mode selection, prescaler, clock source and oversampling of one channel
//
// Contract
// - Reset clears FIFO enable: byte mode
// - FIFO enable clear: depth one, ignore rest
// - Enable, no enhanced, no deep, no strap: 16 deep
// - Strap high, enabled, not enhanced: 128 deep
// - Deep bit enlarges FIFOs to 128
// - Deep bit writable only with divisor access
// - Deep bit, auto RTS/CTS, alt sleep non-enhanced
// - Enhanced plus enabled: 128 regardless of strap
// - Enhanced mode removes legacy enhanced feature set
// - Arbitrary trigger uses four level registers
// - Fill levels and flow status are readable
// - Prescaler divides by M plus N/8
// - Prescaler resets to divide by four
// - Clock source selects external bit clocks
// - Oversample resets zero; 0..3 give 16
// - Oversample 4..15 used exactly
// - Identification, FIFO control readback, soft reset
// - Enhanced mode unlocks extended feature set
// - Channels share clock, strap, reset config
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module umc_mode_clk_cfg #(
   parameter logic [31:0] IDENT = 32'h0a5c_3e71 // Arbitrary identification
) (
   input  wire logic             ref_clk,           // System clock
   input  wire logic             rst,               // Async reset, high
   input  wire logic [7:0]       reg_addr,          // Register address
   input  wire logic [7:0]       reg_wdata,         // Write data
   input  wire logic             reg_wr,            // Write strobe
   input  wire logic             reg_rd,            // Read strobe
   output logic [7:0]            reg_rdata,         // Read data, next cycle
   input  wire logic             fifo_depth_strap,  // FIFO size strap pin
   input  wire logic             ri_n_pin,          // Ring indicator pin
   input  wire logic             dsr_n_pin,         // DSR pin
   input  wire logic             dtr_pin_in,        // DTR pin level
   output logic                  dtr_pin_out,       // DTR pin drive value
   output logic                  dtr_pin_oe,        // DTR pin driven
   input  wire logic             dtr_level,         // DTR from modem logic
   input  wire logic             baud_prescale_sel, // Prescaler requested
   input  wire logic [7:0]       rx_fill_level,     // Receive FIFO count
   input  wire logic [7:0]       tx_fill_level,     // Transmit FIFO count
   input  wire logic             local_tx_flow_off, // Our tx held off
   input  wire logic             remote_tx_flow_off,// Far tx held off
   output logic [7:0]            fifo_depth,        // Effective depth
   output umc_pkg::umc_mode_e    uart_mode,         // Compatibility mode
   output umc_pkg::umc_feat_s    features,          // Available features
   output umc_pkg::umc_trig_s    triggers,          // Effective thresholds
   output logic [4:0]            samples_per_bit,   // Sample clocks per bit
   output logic                  tx_sample_tick,    // Transmit sample pulse
   output logic                  rx_sample_tick,    // Receive sample pulse
   output logic                  tx_bit_tick,       // Transmit bit boundary
   output logic                  flush_rx,          // Receive flush pulse
   output logic                  flush_tx,          // Transmit flush pulse
   output logic                  chan_soft_rst      // Channel reset pulse
);

   // Depth selection used by the depth decode only
   function automatic logic [7:0] umc_depth(input logic en,
                                            input logic enh,
                                            input logic deep,
                                            input logic strap);
      if (!en)
         return umc_pkg::DEPTH_BYTE;
      else if (enh || strap || deep)
         return umc_pkg::DEPTH_DEEP;
      else
         return umc_pkg::DEPTH_STD;
   endfunction

   // Configuration registers
   logic [7:0] fcr_q;      // fifo_control_reg
   logic [7:0] efr_q;      // enhanced_feature_reg
   logic [7:0] lcr_q;      // line_format_reg
   logic [7:0] acr_q;      // additional_control_reg
   logic [7:0] rx_thr_q;   // rx_interrupt_threshold
   logic [7:0] tx_thr_q;   // Transmit threshold level
   logic [7:0] fcl_q;      // flow_off_low_threshold
   logic [7:0] fch_q;      // flow_on_high_threshold
   logic [7:0] cpr_q;      // clock_prescaler
   logic [7:0] cks_q;      // clock_source_select
   logic [7:0] tcr_q;      // oversample_count
   logic       flush_rx_q; // Flush pulse registers
   logic       flush_tx_q;
   logic       srst_q;     // Soft reset pulse

   // Pin synchronisers: strap, ri, dsr, dtr
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] sync3_q;
   logic [3:0] filt_q;     // Agreed levels
   logic [3:0] filt_d;
   logic [3:0] rise;       // Rising edges of agreed levels

   // Clock generation
   logic [8:0] acc_q;      // Fractional accumulator in eighths
   logic [8:0] acc_d;
   logic [8:0] acc_sum;
   logic [7:0] div8;       // Division in eighths, clamped
   logic       pre_tick_q; // Prescaled clock pulse
   logic       pre_active;
   logic [4:0] ovs_cnt_q;  // Samples within current bit

   logic       enh;
   logic       fifo_en;
   logic       wr_any;
   logic [7:0] rd_d;

   assign enh     = efr_q[umc_pkg::EFR_ENH_BIT];
   assign fifo_en = fcr_q[umc_pkg::FCR_EN_BIT];
   assign wr_any  = reg_wr && !srst_q;

   // Config registers; hard and soft reset load the same values
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fcr_q    <= umc_pkg::FCR_RST;
         efr_q    <= umc_pkg::CFG_RST;
         lcr_q    <= umc_pkg::CFG_RST;
         acr_q    <= umc_pkg::CFG_RST;
         rx_thr_q <= umc_pkg::CFG_RST;
         tx_thr_q <= umc_pkg::CFG_RST;
         fcl_q    <= umc_pkg::CFG_RST;
         fch_q    <= umc_pkg::CFG_RST;
         cpr_q    <= umc_pkg::CPR_RST;
         cks_q    <= umc_pkg::CFG_RST;
         tcr_q    <= umc_pkg::TCR_RST;
      end else if (srst_q) begin
         // Soft reset returns the channel to its power-on state
         fcr_q    <= umc_pkg::FCR_RST;
         efr_q    <= umc_pkg::CFG_RST;
         lcr_q    <= umc_pkg::CFG_RST;
         acr_q    <= umc_pkg::CFG_RST;
         rx_thr_q <= umc_pkg::CFG_RST;
         tx_thr_q <= umc_pkg::CFG_RST;
         fcl_q    <= umc_pkg::CFG_RST;
         fch_q    <= umc_pkg::CFG_RST;
         cpr_q    <= umc_pkg::CPR_RST;
         cks_q    <= umc_pkg::CFG_RST;
         tcr_q    <= umc_pkg::TCR_RST;
      end else if (wr_any) begin
         case (reg_addr)
            umc_pkg::OFS_FIFO_CTRL: begin
               // Flush bits are actions, never stored
               fcr_q[7:6] <= reg_wdata[7:6];
               fcr_q[4:3] <= reg_wdata[4:3];
               fcr_q[0]   <= reg_wdata[0];
               // Deep bit guarded by divisor access
               if (lcr_q[umc_pkg::LCR_DLAB_BIT])
                  fcr_q[5] <= reg_wdata[5];
            end
            umc_pkg::OFS_ENH_FEAT:   efr_q    <= reg_wdata;
            umc_pkg::OFS_LINE_FMT:   lcr_q    <= reg_wdata;
            umc_pkg::OFS_ADD_CTRL:   acr_q    <= reg_wdata;
            umc_pkg::OFS_RX_THR:     rx_thr_q <= reg_wdata;
            umc_pkg::OFS_TX_THR:     tx_thr_q <= reg_wdata;
            umc_pkg::OFS_FLOW_LO:    fcl_q    <= reg_wdata;
            umc_pkg::OFS_FLOW_HI:    fch_q    <= reg_wdata;
            umc_pkg::OFS_PRESCALER:  cpr_q    <= reg_wdata;
            umc_pkg::OFS_CLK_SRC:    cks_q    <= reg_wdata;
            umc_pkg::OFS_OVERSAMPLE: tcr_q    <= reg_wdata;
            default: ;                 // Other addresses hold nothing
         endcase
      end
   end

   // One-cycle action pulses from writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flush_rx_q <= 1'b0;
         flush_tx_q <= 1'b0;
         srst_q     <= 1'b0;
      end else begin
         flush_rx_q <= wr_any && reg_addr == umc_pkg::OFS_FIFO_CTRL &&
                       reg_wdata[umc_pkg::FCR_FLUSH_RX_BIT];
         flush_tx_q <= wr_any && reg_addr == umc_pkg::OFS_FIFO_CTRL &&
                       reg_wdata[umc_pkg::FCR_FLUSH_TX_BIT];
         // Soft reset only exists in enhanced mode
         srst_q     <= wr_any && reg_addr == umc_pkg::OFS_SOFT_RST &&
                       enh;
      end
   end

   assign flush_rx      = flush_rx_q;
   assign flush_tx      = flush_tx_q;
   assign chan_soft_rst = srst_q;

   // Mode and depth follow the registers with no extra latency
   always_comb begin
      fifo_depth = umc_depth(fifo_en, enh, fcr_q[umc_pkg::FCR_DEEP_BIT],
                             filt_q[0]);
      if (!fifo_en)
         uart_mode = umc_pkg::UMC_MODE_450;
      else if (enh)
         uart_mode = umc_pkg::UMC_MODE_650;
      else if (filt_q[0])
         uart_mode = umc_pkg::UMC_MODE_EXT550;
      else if (fcr_q[umc_pkg::FCR_DEEP_BIT])
         uart_mode = umc_pkg::UMC_MODE_750;
      else
         uart_mode = umc_pkg::UMC_MODE_550;
   end

   // Feature set: legacy extras only outside enhanced mode
   always_comb begin
      features              = '0;
      features.alt_sleep    = !enh;
      features.auto_rts_cts = !enh;
      features.sleep        = enh;
      features.inband_flow  = enh;
      features.special_char = enh;
      features.infrared     = enh;
      features.tx_trigger   = enh;
      features.prescaler    = enh;
      features.dsr_dtr_flow = enh;
      features.txrx_disable = enh;
      features.rs485_de     = enh;
      features.nine_bit     = enh;
      features.ident_read   = enh;
   end

   // Thresholds: level registers or legacy FIFO control codes
   always_comb begin
      triggers = '0;
      triggers.arbitrary = acr_q[umc_pkg::ACR_ARB_TRIG_BIT];
      if (triggers.arbitrary) begin
         // Upper FIFO control bits are ignored here
         triggers.rx_thr  = rx_thr_q;
         triggers.tx_thr  = tx_thr_q;
         triggers.flow_lo = fcl_q;
         triggers.flow_hi = fch_q;
      end else begin
         // Legacy two-bit trigger codes in the low bits
         triggers.rx_thr  = {6'h00, fcr_q[7:6]};
         triggers.tx_thr  = {6'h00, fcr_q[5:4]};
      end
   end

   // Three-stage synchronisers for pins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         sync3_q <= 4'h0;
         filt_q  <= 4'h0;
      end else begin
         sync1_q <= {dtr_pin_in, !dsr_n_pin, !ri_n_pin, fifo_depth_strap};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q  <= filt_d;
      end
   end

   // A level is accepted once the two later stages agree
   assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
   assign rise   = filt_d & ~filt_q;

   // DTR pin is released when it carries the transmit clock
   assign dtr_pin_oe  = !(cks_q[umc_pkg::CKS_TX_EXT_BIT] &&
                          cks_q[umc_pkg::CKS_TX_DTR_BIT]);
   assign dtr_pin_out = dtr_level;

   // Prescaler: add eight per clock, tick when the division is reached
   assign pre_active = enh && baud_prescale_sel;
   assign div8       = (cpr_q < umc_pkg::PRE_MIN) ? umc_pkg::PRE_MIN
                                                  : cpr_q;
   assign acc_sum    = acc_q + umc_pkg::PRE_STEP;

   always_comb begin
      if (acc_sum >= {1'b0, div8})
         acc_d = acc_sum - {1'b0, div8};
      else
         acc_d = acc_sum;
   end

   // Fractional divider; bypassed gives a tick each clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acc_q      <= 9'h000;
         pre_tick_q <= 1'b0;
      end else if (!pre_active) begin
         acc_q      <= 9'h000;
         pre_tick_q <= 1'b1;
      end else begin
         acc_q      <= acc_d;
         pre_tick_q <= acc_sum >= {1'b0, div8};
      end
   end

   // Sample clocks: internal or external bit clocks
   always_comb begin
      if (cks_q[umc_pkg::CKS_TX_EXT_BIT])
         tx_sample_tick = cks_q[umc_pkg::CKS_TX_DTR_BIT] ? rise[3]
                                                         : rise[1];
      else
         tx_sample_tick = pre_tick_q;
      rx_sample_tick = cks_q[umc_pkg::CKS_RX_EXT_BIT] ? rise[2]
                                                      : pre_tick_q;
   end

   // Low settings fall back to sixteen samples
   assign samples_per_bit = (tcr_q[3:0] < umc_pkg::OVS_MIN) ?
                            umc_pkg::OVS_LEGACY :
                            {1'b0, tcr_q[3:0]};

   // Bit boundary every samples_per_bit transmit sample ticks
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         ovs_cnt_q <= 5'h00;
      else if (tx_sample_tick) begin
         if (ovs_cnt_q >= samples_per_bit - 5'h01)
            ovs_cnt_q <= 5'h00;
         else
            ovs_cnt_q <= ovs_cnt_q + 5'h01;
      end
   end

   assign tx_bit_tick = tx_sample_tick &&
                        ovs_cnt_q >= samples_per_bit - 5'h01;

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_d = 8'h00;
      case (reg_addr)
         umc_pkg::OFS_FIFO_CTRL:  rd_d = enh ? fcr_q : 8'h00;
         umc_pkg::OFS_ENH_FEAT:   rd_d = efr_q;
         umc_pkg::OFS_LINE_FMT:   rd_d = lcr_q;
         umc_pkg::OFS_ADD_CTRL:   rd_d = acr_q;
         umc_pkg::OFS_RX_THR:     rd_d = rx_thr_q;
         umc_pkg::OFS_TX_THR:     rd_d = tx_thr_q;
         umc_pkg::OFS_FLOW_LO:    rd_d = fcl_q;
         umc_pkg::OFS_FLOW_HI:    rd_d = fch_q;
         umc_pkg::OFS_PRESCALER:  rd_d = cpr_q;
         umc_pkg::OFS_CLK_SRC:    rd_d = cks_q;
         umc_pkg::OFS_OVERSAMPLE: rd_d = tcr_q;
         umc_pkg::OFS_ADD_STAT:
            rd_d = {6'h00, remote_tx_flow_off, local_tx_flow_off};
         umc_pkg::OFS_RX_FILL:    rd_d = rx_fill_level;
         umc_pkg::OFS_TX_FILL:    rd_d = tx_fill_level;
         umc_pkg::OFS_MODE_STAT:  rd_d = {5'h00, uart_mode};
         default: begin
            // Identification bytes, least significant first
            if (enh && reg_addr >= umc_pkg::OFS_ID0 &&
                reg_addr <= umc_pkg::OFS_ID3)
               rd_d = IDENT[8*(reg_addr[1:0]) +: 8];
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rd_d : 8'h00;
   end

   // Checks
   property p_reset_byte;
      @(posedge ref_clk) $fell(rst) |-> fifo_depth == umc_pkg::DEPTH_BYTE &&
         cpr_q == umc_pkg::CPR_RST && tcr_q == umc_pkg::TCR_RST;
   endproperty
   a_reset_byte: assert property (p_reset_byte)
      else $error("reset values wrong");

   property p_byte_mode;
      @(posedge ref_clk) disable iff (rst)
      !fifo_en |-> fifo_depth == umc_pkg::DEPTH_BYTE &&
                   uart_mode == umc_pkg::UMC_MODE_450;
   endproperty
   a_byte_mode: assert property (p_byte_mode)
      else $error("byte mode depth wrong");

   property p_std_depth;
      @(posedge ref_clk) disable iff (rst)
      fifo_en && !enh && !fcr_q[umc_pkg::FCR_DEEP_BIT] && !filt_q[0]
         |-> fifo_depth == umc_pkg::DEPTH_STD;
   endproperty
   a_std_depth: assert property (p_std_depth)
      else $error("sixteen deep expected");

   property p_deep_depth;
      @(posedge ref_clk) disable iff (rst)
      fifo_en && (enh || filt_q[0] || fcr_q[umc_pkg::FCR_DEEP_BIT])
         |-> fifo_depth == umc_pkg::DEPTH_DEEP;
   endproperty
   a_deep_depth: assert property (p_deep_depth)
      else $error("deep FIFO expected");

   property p_deep_guard;
      @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == umc_pkg::OFS_FIFO_CTRL &&
      !lcr_q[umc_pkg::LCR_DLAB_BIT] && !srst_q
         |=> $stable(fcr_q[umc_pkg::FCR_DEEP_BIT]);
   endproperty
   a_deep_guard: assert property (p_deep_guard)
      else $error("deep bit changed without guard");

   property p_legacy_feat;
      @(posedge ref_clk) disable iff (rst)
      features.auto_rts_cts == !enh && features.sleep == enh &&
      features.rs485_de == enh;
   endproperty
   a_legacy_feat: assert property (p_legacy_feat)
      else $error("feature gating wrong");

   property p_arb_trig;
      @(posedge ref_clk) disable iff (rst)
      acr_q[umc_pkg::ACR_ARB_TRIG_BIT] |-> triggers.rx_thr == rx_thr_q &&
         triggers.flow_hi == fch_q;
   endproperty
   a_arb_trig: assert property (p_arb_trig)
      else $error("arbitrary thresholds not used");

   sequence s_fill_read;
      reg_rd && reg_addr == umc_pkg::OFS_RX_FILL;
   endsequence
   property p_fill_read;
      @(posedge ref_clk) disable iff (rst)
      s_fill_read |=> reg_rdata == $past(rx_fill_level) ##1 reg_rdata ==
         8'h00 || $past(reg_rd);
   endproperty
   a_fill_read: assert property (p_fill_read)
      else $error("fill level read wrong");

   sequence s_div4_gap;
      !pre_tick_q [*3] ##1 pre_tick_q;
   endsequence
   // Leaving the prescaled path mid-period is legal, so it ends the check
   property p_div4;
      @(posedge ref_clk) disable iff (rst || !pre_active)
      pre_tick_q && pre_active && cpr_q == umc_pkg::CPR_RST &&
      $past(pre_active) |=> s_div4_gap;
   endproperty
   a_div4: assert property (p_div4)
      else $error("prescaler period not four");

   property p_ovs;
      @(posedge ref_clk) disable iff (rst)
      (tcr_q[3:0] < umc_pkg::OVS_MIN) ? samples_per_bit == 5'h10 :
                                        samples_per_bit == tcr_q[3:0];
   endproperty
   a_ovs: assert property (p_ovs)
      else $error("oversample count wrong");

endmodule // umc_mode_clk_cfg

/* umc_pkg.sv */
// Constants, field layout and carrier types of the mode and clock config block
package umc_pkg;

   // Register offsets on the flat configuration port
   localparam logic [7:0] OFS_PRESCALER  = 8'h01;
   localparam logic [7:0] OFS_CLK_SRC    = 8'h02;
   localparam logic [7:0] OFS_OVERSAMPLE = 8'h03;
   localparam logic [7:0] OFS_FIFO_CTRL  = 8'h10;
   localparam logic [7:0] OFS_ENH_FEAT   = 8'h11;
   localparam logic [7:0] OFS_LINE_FMT   = 8'h12;
   localparam logic [7:0] OFS_ADD_CTRL   = 8'h13;
   localparam logic [7:0] OFS_RX_THR     = 8'h14;
   localparam logic [7:0] OFS_TX_THR     = 8'h15;
   localparam logic [7:0] OFS_FLOW_LO    = 8'h16;
   localparam logic [7:0] OFS_FLOW_HI    = 8'h17;
   localparam logic [7:0] OFS_ADD_STAT   = 8'h18;
   localparam logic [7:0] OFS_RX_FILL    = 8'h19;
   localparam logic [7:0] OFS_TX_FILL    = 8'h1a;
   localparam logic [7:0] OFS_MODE_STAT  = 8'h1b;
   localparam logic [7:0] OFS_SOFT_RST   = 8'h1c;
   localparam logic [7:0] OFS_ID0        = 8'h20;
   localparam logic [7:0] OFS_ID3        = 8'h23;

   // Field positions
   localparam int FCR_EN_BIT       = 0;
   localparam int FCR_FLUSH_RX_BIT = 1;
   localparam int FCR_FLUSH_TX_BIT = 2;
   localparam int FCR_DEEP_BIT     = 5;
   localparam int EFR_ENH_BIT      = 4;
   localparam int LCR_DLAB_BIT     = 7;
   localparam int ACR_ARB_TRIG_BIT = 5;
   localparam int CKS_RX_EXT_BIT   = 0;
   localparam int CKS_TX_EXT_BIT   = 1;
   localparam int CKS_TX_DTR_BIT   = 2;

   // Reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] FCR_RST = 8'h00;
   localparam logic [7:0] CPR_RST = 8'h20;
   localparam logic [7:0] TCR_RST = 8'h00;

   // FIFO depths and sample counts
   localparam logic [7:0] DEPTH_BYTE = 8'h01;
   localparam logic [7:0] DEPTH_STD  = 8'h10;
   localparam logic [7:0] DEPTH_DEEP = 8'h80;
   localparam logic [4:0] OVS_LEGACY = 5'h10;
   localparam logic [3:0] OVS_MIN    = 4'h4;

   // Prescaler works in eighths of a clock
   localparam logic [8:0] PRE_STEP = 9'h008;
   localparam logic [7:0] PRE_MIN  = 8'h08;

   // Compatibility modes
   typedef enum logic [2:0] {
      UMC_MODE_450,
      UMC_MODE_550,
      UMC_MODE_EXT550,
      UMC_MODE_750,
      UMC_MODE_650
   } umc_mode_e;

   // Feature availability flags
   typedef struct packed {
      logic alt_sleep;
      logic auto_rts_cts;
      logic sleep;
      logic inband_flow;
      logic special_char;
      logic infrared;
      logic tx_trigger;
      logic prescaler;
      logic dsr_dtr_flow;
      logic txrx_disable;
      logic rs485_de;
      logic nine_bit;
      logic ident_read;
   } umc_feat_s;

   // Effective thresholds
   typedef struct packed {
      logic       arbitrary;
      logic [7:0] rx_thr;
      logic [7:0] tx_thr;
      logic [7:0] flow_lo;
      logic [7:0] flow_hi;
   } umc_trig_s;

endpackage

/* umc_remote.sv */
// Remote serial device model: external bit clocks and flow status
`timescale 1ns/10ps
module umc_remote (
   input  wire logic ref_clk,  // System clock
   input  wire logic rst,      // Async reset, high
   input  wire logic dtr_out,  // DTR drive value
   input  wire logic dtr_oe,   // DTR driven by the block
   output logic      ri_n,     // Ring indicator, tx bit clock
   output logic      dsr_n,    // DSR, rx bit clock
   output logic      dtr_lvl,  // Resolved DTR wire level
   output logic      flow_off  // Remote transmitter held off
);
   logic [3:0] div_q; // Bit clock divider
   // Slow clock, so each pin edge clears the synchroniser
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) div_q <= 4'h0;
      else div_q <= div_q + 4'h1;
   end
   assign ri_n = div_q[3];
   assign dsr_n = ~div_q[3];
   // Block released DTR: far side clocks the wire instead
   assign dtr_lvl = dtr_oe ? dtr_out : div_q[2];
   assign flow_off = 1'b1;    // Far transmitter always held off
endmodule // umc_remote

/* tb_umc_mode_clk_cfg.sv */
// Testbench of the mode and clock config block
`timescale 1ns/10ps
module tb_umc_mode_clk_cfg;
   logic       ref_clk, rst, reg_wr, reg_rd, strap, ri_n, dsr_n, dtr_lvl;
   logic       dtr_out, dtr_oe, far_off, rx_tick, psel, tx_tick, bit_tick;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_depth;
   logic [4:0] spb;     // Samples per bit
   umc_pkg::umc_mode_e mode;
   umc_pkg::umc_trig_s trig; // Effective thresholds
   int         num_errors, checks, cycles, n, b;
   initial begin ref_clk = 1'b0; forever #12.5 ref_clk = ~ref_clk; end
   umc_mode_clk_cfg #(.IDENT(32'h1234_5678)) dut ( // Arbitrary identity
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fifo_depth_strap(strap), .ri_n_pin(ri_n),
      .dsr_n_pin(dsr_n), .dtr_pin_in(dtr_lvl), .dtr_pin_out(dtr_out),
      .dtr_pin_oe(dtr_oe), .dtr_level(1'b1), .baud_prescale_sel(psel),
      .rx_fill_level(8'h5a), .tx_fill_level(8'h21),
      .local_tx_flow_off(1'b0), .remote_tx_flow_off(far_off),
      .fifo_depth(fifo_depth), .uart_mode(mode), .features(),
      .triggers(trig), .samples_per_bit(spb), .tx_sample_tick(tx_tick),
      .rx_sample_tick(rx_tick), .tx_bit_tick(bit_tick), .flush_rx(),
      .flush_tx(), .chan_soft_rst());
   umc_remote far (.ref_clk(ref_clk), .rst(rst), .dtr_out(dtr_out),
      .dtr_oe(dtr_oe), .ri_n(ri_n), .dsr_n(dsr_n), .dtr_lvl(dtr_lvl),
      .flow_off(far_off));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe, then let the edge land
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge ref_clk); reg_wr <= 1'b0; @(posedge ref_clk); #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge ref_clk); reg_rd <= 1'b0; #1; chk(reg_rdata, exp);
      @(posedge ref_clk);
   endtask
   task automatic print_verdict;
      $display("counts: %0d checks, %0d mismatches", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard, well above the length of the sequence
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin num_errors++; print_verdict(); end
   end
   initial begin
      num_errors = 0; checks = 0; cycles = 0; rst = 1'b1; strap = 1'b0;
      reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      psel = 1'b0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0; @(posedge ref_clk); #1;
      chk(fifo_depth, umc_pkg::DEPTH_BYTE);
      chk(8'(spb), 8'h10);
      rd(umc_pkg::OFS_OVERSAMPLE, 8'h00);
      rd(umc_pkg::OFS_PRESCALER, 8'h20);
      $display("test reset done");
      wr(umc_pkg::OFS_FIFO_CTRL, 8'h01);
      chk(fifo_depth, umc_pkg::DEPTH_STD);
      chk(8'(mode), 8'(umc_pkg::UMC_MODE_550));
      wr(umc_pkg::OFS_FIFO_CTRL, 8'h21);
      chk(fifo_depth, umc_pkg::DEPTH_STD);
      wr(umc_pkg::OFS_LINE_FMT, 8'h80);
      wr(umc_pkg::OFS_FIFO_CTRL, 8'h21);
      wr(umc_pkg::OFS_LINE_FMT, 8'h00);
      chk(fifo_depth, umc_pkg::DEPTH_DEEP);
      chk(8'(mode), 8'(umc_pkg::UMC_MODE_750));
      wr(umc_pkg::OFS_FIFO_CTRL, 8'h00);
      chk(fifo_depth, umc_pkg::DEPTH_BYTE);
      $display("test fifo modes done");
      strap <= 1'b1; repeat (6) @(posedge ref_clk); #1;
      chk(fifo_depth, umc_pkg::DEPTH_BYTE);
      wr(umc_pkg::OFS_FIFO_CTRL, 8'h01);
      chk(fifo_depth, umc_pkg::DEPTH_DEEP);
      strap <= 1'b0; repeat (6) @(posedge ref_clk); #1;
      wr(umc_pkg::OFS_ENH_FEAT, 8'h10);
      chk(fifo_depth, umc_pkg::DEPTH_DEEP);
      rd(umc_pkg::OFS_ID0, 8'h78);
      rd(umc_pkg::OFS_ID3, 8'h12);
      rd(umc_pkg::OFS_RX_FILL, 8'h5a);
      rd(umc_pkg::OFS_TX_FILL, 8'h21);
      rd(umc_pkg::OFS_ADD_STAT, 8'h02);
      rd(8'h7f, 8'h00);
      wr(umc_pkg::OFS_ADD_CTRL, 8'h20);
      wr(umc_pkg::OFS_RX_THR, 8'h33);
      chk(trig.rx_thr, 8'h33);
      $display("test strap and enhanced done");
      for (int i = 0; i < 16; i++) begin
         wr(umc_pkg::OFS_OVERSAMPLE, 8'(i));
         chk(8'(spb), (i < 4) ? 8'h10 : 8'(i));
      end
      $display("test oversampling done");
      // Prescaler: reset value divides by four, 0x0c by one and a half
      psel <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      n = 0;
      repeat (64) begin
         @(posedge ref_clk); #1; n += int'(rx_tick === 1'b1);
      end
      chk(8'(n), 8'h10);
      psel <= 1'b0;
      wr(umc_pkg::OFS_PRESCALER, 8'h0c);
      psel <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      n = 0;
      repeat (48) begin
         @(posedge ref_clk); #1; n += int'(rx_tick === 1'b1);
      end
      chk(8'(n), 8'h20);
      psel <= 1'b0;
      $display("test prescaler done");
      // Rx clock from DSR: about one tick per 16 clocks, not every cycle
      wr(umc_pkg::OFS_CLK_SRC, 8'h01);
      n = 0;
      repeat (64) begin @(posedge ref_clk); #1; n += int'(rx_tick === 1'b1); end
      chk(8'(n >= 3 && n <= 5), 8'h01);
      // Tx clock from the released DTR wire, a bit every four samples
      wr(umc_pkg::OFS_OVERSAMPLE, 8'h04);
      wr(umc_pkg::OFS_CLK_SRC, 8'h06);
      chk(8'(dtr_oe), 8'h00);
      repeat (8) @(posedge ref_clk);
      n = 0;
      b = 0;
      repeat (64) begin
         @(posedge ref_clk); #1;
         n += int'(tx_tick === 1'b1);
         b += int'(bit_tick === 1'b1);
      end
      chk(8'(n), 8'h08);
      chk(8'(b), 8'h02);
      // Soft reset in enhanced mode restores the power-on settings
      wr(umc_pkg::OFS_SOFT_RST, 8'h00);
      chk(fifo_depth, umc_pkg::DEPTH_BYTE);
      rd(umc_pkg::OFS_PRESCALER, umc_pkg::CPR_RST);
      $display("test clock source done");
      print_verdict();
   end
endmodule // tb_umc_mode_clk_cfg
